// ===== core/tset_pkg.sv
package tset_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_SWEVT = 8'h14;
   localparam logic [7:0] OFS_CHCTL0 = 8'h18;
   localparam logic [7:0] OFS_ARLD = 8'h2C;
   localparam logic [7:0] OFS_CNT = 8'h24;
   localparam logic [7:0] OFS_CV0 = 8'h34;
   localparam logic [7:0] OFS_CV1 = 8'h38;
   localparam logic [7:0] OFS_INTSTAT = 8'h40;
   localparam logic [7:0] OFS_INTMASK = 8'h44;
   // software event trigger bits
   localparam int BIT_UPD = 0;
   localparam int BIT_CH0 = 1;
   localparam int BIT_CH1 = 2;
   // control register fields
   localparam int CTRL_EN = 0;
   localparam int CTRL_DIR_LO = 4;
   localparam int CTRL_PSC_LO = 8;
   localparam int CTRL_REQ0 = 16;
   localparam int CTRL_REQ1 = 17;
   localparam int CTRL_DMA0 = 18;
   localparam int CTRL_DMA1 = 19;
   // channel control: bit 0 / bit 8 = input mode for channel 0 / 1
   localparam int CHC_IN0 = 0;
   localparam int CHC_IN1 = 8;
   // status bits: flag0 flag1 over0 over1 update
   localparam int ST_F0 = 0;
   localparam int ST_F1 = 1;
   localparam int ST_O0 = 2;
   localparam int ST_O1 = 3;
   localparam int ST_UPD = 4;
   localparam int NUM_ST = 5;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [15:0] RST_ARLD = 16'hFFFF;
   localparam int WAIT_CYC = 1;

   typedef enum logic [1:0] {
      TSET_DIR_UP = 2'h0,
      TSET_DIR_DOWN = 2'h1,
      TSET_DIR_CENTER = 2'h2
   } tset_dir_t;

   typedef enum logic [2:0] {
      TSET_BUS_IDLE = 3'h1,
      TSET_BUS_WAIT = 3'h2,
      TSET_BUS_DONE = 3'h4
   } tset_bus_state_t;

   typedef struct packed {
      logic upd;
      logic ch0;
      logic ch1;
   } tset_trig_t;

   typedef struct packed {
      logic read;
      logic write;
      logic [7:0] address;
      logic [31:0] writedata;
   } tset_req_t;
endpackage

// ===== core/tset_counter.sv
`timescale 1ns/10ps
// counter with prescaler; software update reinitialises both
module tset_counter (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // control
   input wire logic i_en,
   input wire tset_pkg::tset_dir_t i_dir,
   input wire logic [15:0] i_psc,
   input wire logic [15:0] i_arld,
   input wire logic i_upd,
   // state
   output logic [15:0] o_cnt,
   output logic [15:0] o_psc_cnt
);
   logic [15:0] cnt_d, cnt_q, psc_d, psc_q;
   logic down_d, down_q;

   always_comb begin
      cnt_d = cnt_q;
      psc_d = psc_q;
      down_d = down_q;
      if (i_upd) begin
         psc_d = 16'h0000;
         if (i_dir == tset_pkg::TSET_DIR_DOWN) begin
            cnt_d = i_arld;
            down_d = 1'b1;
         end else begin
            cnt_d = 16'h0000;
            down_d = 1'b0;
         end
      end else if (i_en) begin
         if (psc_q >= i_psc) begin
            psc_d = 16'h0000;
            case (i_dir)
               tset_pkg::TSET_DIR_UP: begin
                  cnt_d = (cnt_q >= i_arld) ? 16'h0000 : 16'(cnt_q + 16'h0001);
               end
               tset_pkg::TSET_DIR_DOWN: begin
                  cnt_d = (cnt_q == 16'h0000) ? i_arld : 16'(cnt_q - 16'h0001);
               end
               default: begin
                  if (!down_q) begin
                     if (cnt_q >= i_arld) begin
                        down_d = 1'b1;
                        cnt_d = 16'(cnt_q - 16'h0001);
                     end else begin
                        cnt_d = 16'(cnt_q + 16'h0001);
                     end
                  end else begin
                     if (cnt_q <= 16'h0001) begin
                        down_d = 1'b0;
                     end
                     cnt_d = (cnt_q == 16'h0000) ? 16'h0001 : 16'(cnt_q - 16'h0001);
                  end
               end
            endcase
         end else begin
            psc_d = 16'(psc_q + 16'h0001);
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         cnt_q <= 16'h0000;
         psc_q <= 16'h0000;
         down_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         psc_q <= psc_d;
         down_q <= down_d;
      end
   end

   assign o_cnt = cnt_q;
   assign o_psc_cnt = psc_q;

   upd_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_upd |=> o_psc_cnt == 16'h0000) else $error("prescaler not cleared by update");
   upd_down_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_upd && i_dir == tset_pkg::TSET_DIR_DOWN |=> o_cnt == $past(i_arld))
      else $error("down update did not load reload");
   upd_up_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_upd && i_dir != tset_pkg::TSET_DIR_DOWN |=> o_cnt == 16'h0000)
      else $error("up update did not clear counter");
endmodule // tset_counter

// ===== core/tset_channel.sv
`timescale 1ns/10ps
// one capture channel: forced event, capture value, overcapture
module tset_channel (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst,
   // control
   input wire logic i_gen,
   input wire logic i_input_mode,
   input wire logic [15:0] i_cnt,
   input wire logic i_flag_clr,
   input wire logic i_over_clr,
   // state
   output logic o_flag,
   output logic o_over,
   output logic o_evt,
   output logic [15:0] o_cv
);
   logic flag_d, flag_q, over_d, over_q;
   logic [15:0] cv_d, cv_q;

   always_comb begin
      flag_d = flag_q;
      over_d = over_q;
      cv_d = cv_q;
      if (i_flag_clr) begin
         flag_d = 1'b0;
      end
      if (i_over_clr) begin
         over_d = 1'b0;
      end
      // set wins over a clear in the same cycle
      if (i_gen) begin
         flag_d = 1'b1;
         if (i_input_mode) begin
            cv_d = i_cnt;
            if (flag_q) begin
               over_d = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         flag_q <= 1'b0;
         over_q <= 1'b0;
         cv_q <= 16'h0000;
      end else begin
         flag_q <= flag_d;
         over_q <= over_d;
         cv_q <= cv_d;
      end
   end

   assign o_flag = flag_q;
   assign o_over = over_q;
   assign o_evt = i_gen;
   assign o_cv = cv_q;

   cap_value_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_gen && i_input_mode |=> o_cv == $past(i_cnt)) else $error("capture value wrong");
   over_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
      i_gen && i_input_mode && o_flag |=> o_over) else $error("overcapture not flagged");
   over_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
      !o_over && !(i_gen && i_input_mode) |=> !o_over) else $error("spurious overcapture");
endmodule // tset_channel

// ===== core/tset_top.sv
`timescale 1ns/10ps
module tset_top (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST,
   // avalon-mm slave
   input wire logic [7:0] I_ADDRESS,
   input wire logic I_READ,
   input wire logic I_WRITE,
   input wire logic [3:0] I_BYTEENABLE,
   input wire logic [31:0] I_WRITEDATA,
   output logic [31:0] O_READDATA,
   output logic O_WAITREQUEST,
   output logic [1:0] O_RESPONSE,
   // requests
   output logic O_IRQ,
   output logic O_DMA_REQ0,
   output logic O_DMA_REQ1,
   // state
   output logic O_CH0_EVT,
   output logic O_CH1_EVT,
   output logic O_UPD_EVT
);
   tset_pkg::tset_bus_state_t st_d, st_q;
   tset_pkg::tset_req_t req;
   tset_pkg::tset_trig_t trig_d, trig_q;
   logic [31:0] ctrl_d, ctrl_q, chctl0_d, chctl0_q, rdata_d, rdata_q;
   logic [15:0] arld_d, arld_q;
   logic [tset_pkg::NUM_ST-1:0] ist_d, ist_q, imask_d, imask_q, ev_vec;
   logic [1:0] resp_d, resp_q;
   logic [1:0] dma_d, dma_q;
   logic [15:0] cnt, psc_cnt, cv0, cv1;
   logic flag0, flag1, over0, over1, evt0, evt1;
   logic wr_acc, rd_acc, hit, full_word;
   logic clr_f0, clr_f1, clr_o0, clr_o1;
   logic [31:0] status_word;

   assign req = '{read: I_READ, write: I_WRITE, address: I_ADDRESS, writedata: I_WRITEDATA};
   // access completes in TSET_BUS_WAIT: two waitrequest cycles (IDLE and WAIT)
   assign wr_acc = (st_q == tset_pkg::TSET_BUS_WAIT) && req.write;
   assign rd_acc = (st_q == tset_pkg::TSET_BUS_WAIT) && req.read;
   assign full_word = (I_BYTEENABLE == 4'hF);

   always_comb begin
      hit = 1'b1;
      case (req.address)
         tset_pkg::OFS_CTRL, tset_pkg::OFS_STAT, tset_pkg::OFS_SWEVT, tset_pkg::OFS_CHCTL0,
         tset_pkg::OFS_ARLD, tset_pkg::OFS_CNT, tset_pkg::OFS_CV0, tset_pkg::OFS_CV1,
         tset_pkg::OFS_INTSTAT, tset_pkg::OFS_INTMASK: begin
            hit = 1'b1;
         end
         default: begin
            hit = 1'b0;
         end
      endcase
   end

   assign status_word = {27'h0000000, ist_q[tset_pkg::ST_UPD], over1, over0, flag1, flag0};

   // bus handshake
   always_comb begin
      st_d = st_q;
      resp_d = resp_q;
      rdata_d = rdata_q;
      case (st_q)
         tset_pkg::TSET_BUS_IDLE: begin
            if (req.read || req.write) begin
               st_d = tset_pkg::TSET_BUS_WAIT;
            end
         end
         tset_pkg::TSET_BUS_WAIT: begin
            st_d = tset_pkg::TSET_BUS_DONE;
            // partial writes to channel control 0 are refused
            resp_d = (!hit || (req.write && req.address == tset_pkg::OFS_CHCTL0 && !full_word))
               ? 2'h2 : 2'h0;
            rdata_d = 32'h0000_0000;
            if (req.read) begin
               case (req.address)
                  tset_pkg::OFS_CTRL: rdata_d = ctrl_q;
                  tset_pkg::OFS_STAT: rdata_d = status_word;
                  tset_pkg::OFS_SWEVT: rdata_d = 32'h0000_0000;
                  tset_pkg::OFS_CHCTL0: rdata_d = chctl0_q;
                  tset_pkg::OFS_ARLD: rdata_d = {16'h0000, arld_q};
                  tset_pkg::OFS_CNT: rdata_d = {16'h0000, cnt};
                  tset_pkg::OFS_CV0: rdata_d = {16'h0000, cv0};
                  tset_pkg::OFS_CV1: rdata_d = {16'h0000, cv1};
                  tset_pkg::OFS_INTSTAT: rdata_d = {27'h0000000, ist_q};
                  tset_pkg::OFS_INTMASK: rdata_d = {27'h0000000, imask_q};
                  default: rdata_d = 32'h0000_0000;
               endcase
            end
         end
         tset_pkg::TSET_BUS_DONE: begin
            st_d = tset_pkg::TSET_BUS_IDLE;
         end
         default: begin
            st_d = tset_pkg::TSET_BUS_IDLE;
         end
      endcase
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         st_q <= tset_pkg::TSET_BUS_IDLE;
         resp_q <= 2'h0;
         rdata_q <= tset_pkg::RST_WORD;
      end else begin
         st_q <= st_d;
         resp_q <= resp_d;
         rdata_q <= rdata_d;
      end
   end

   assign O_WAITREQUEST = (req.read || req.write) && (st_q != tset_pkg::TSET_BUS_DONE);
   assign O_READDATA = rdata_q;
   assign O_RESPONSE = resp_q;

   // configuration registers and one-shot trigger bits
   always_comb begin
      ctrl_d = ctrl_q;
      chctl0_d = chctl0_q;
      arld_d = arld_q;
      imask_d = imask_q;
      // triggers last one cycle then return to zero
      trig_d = '{upd: 1'b0, ch0: 1'b0, ch1: 1'b0};
      if (wr_acc) begin
         case (req.address)
            tset_pkg::OFS_CTRL: ctrl_d = req.writedata;
            tset_pkg::OFS_CHCTL0: begin
               if (full_word) begin
                  chctl0_d = req.writedata;
               end
            end
            tset_pkg::OFS_ARLD: arld_d = req.writedata[15:0];
            tset_pkg::OFS_INTMASK: imask_d = req.writedata[tset_pkg::NUM_ST-1:0];
            tset_pkg::OFS_SWEVT: begin
               // a zero bit fires nothing
               trig_d.upd = req.writedata[tset_pkg::BIT_UPD];
               trig_d.ch0 = req.writedata[tset_pkg::BIT_CH0];
               trig_d.ch1 = req.writedata[tset_pkg::BIT_CH1];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         ctrl_q <= tset_pkg::RST_WORD;
         chctl0_q <= tset_pkg::RST_WORD;
         arld_q <= tset_pkg::RST_ARLD;
         imask_q <= '0;
         trig_q <= '{upd: 1'b0, ch0: 1'b0, ch1: 1'b0};
      end else begin
         ctrl_q <= ctrl_d;
         chctl0_q <= chctl0_d;
         arld_q <= arld_d;
         imask_q <= imask_d;
         trig_q <= trig_d;
      end
   end

   // reading the flag status clears flags and overcapture bits
   assign clr_f0 = rd_acc && req.address == tset_pkg::OFS_STAT && flag0;
   assign clr_f1 = rd_acc && req.address == tset_pkg::OFS_STAT && flag1;
   assign clr_o0 = rd_acc && req.address == tset_pkg::OFS_STAT && over0;
   assign clr_o1 = rd_acc && req.address == tset_pkg::OFS_STAT && over1;

   tset_counter u_counter (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_en(ctrl_q[tset_pkg::CTRL_EN]),
      .i_dir(tset_pkg::tset_dir_t'(ctrl_q[tset_pkg::CTRL_DIR_LO +: 2])),
      .i_psc(ctrl_q[tset_pkg::CTRL_PSC_LO +: 8] == 8'h00 ? 16'h0000 : {8'h00, ctrl_q[tset_pkg::CTRL_PSC_LO +: 8]}),
      .i_arld(arld_q),
      .i_upd(trig_q.upd),
      .o_cnt(cnt),
      .o_psc_cnt(psc_cnt)
   );

   tset_channel u_ch0 (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_gen(trig_q.ch0),
      .i_input_mode(chctl0_q[tset_pkg::CHC_IN0]),
      .i_cnt(cnt),
      .i_flag_clr(clr_f0),
      .i_over_clr(clr_o0),
      .o_flag(flag0),
      .o_over(over0),
      .o_evt(evt0),
      .o_cv(cv0)
   );

   tset_channel u_ch1 (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_gen(trig_q.ch1),
      .i_input_mode(chctl0_q[tset_pkg::CHC_IN1]),
      .i_cnt(cnt),
      .i_flag_clr(clr_f1),
      .i_over_clr(clr_o1),
      .o_flag(flag1),
      .o_over(over1),
      .o_evt(evt1),
      .o_cv(cv1)
   );

   // sticky interrupt status, cleared by reading it; set wins
   // overcapture enters as an event, not a level, so a status read can clear it
   assign ev_vec = {trig_q.upd, evt1 & chctl0_q[tset_pkg::CHC_IN1] & flag1,
      evt0 & chctl0_q[tset_pkg::CHC_IN0] & flag0, evt1, evt0};

   always_comb begin
      ist_d = ist_q;
      dma_d = 2'h0;
      if (rd_acc && req.address == tset_pkg::OFS_INTSTAT) begin
         ist_d = '0;
      end
      ist_d = ist_d | ev_vec;
      // dma request pulses one cycle after the forced event
      dma_d[0] = evt0 && ctrl_q[tset_pkg::CTRL_DMA0];
      dma_d[1] = evt1 && ctrl_q[tset_pkg::CTRL_DMA1];
   end

   always_ff @(posedge I_CLK_SYS or posedge I_RST) begin
      if (I_RST) begin
         ist_q <= '0;
         dma_q <= 2'h0;
      end else begin
         ist_q <= ist_d;
         dma_q <= dma_d;
      end
   end

   // flag interrupt for a channel also needs its request enable; overcapture does not
   assign O_IRQ = |(ist_q & imask_q & {3'h7, ctrl_q[tset_pkg::CTRL_REQ1], ctrl_q[tset_pkg::CTRL_REQ0]});
   assign O_DMA_REQ0 = dma_q[0];
   assign O_DMA_REQ1 = dma_q[1];
   assign O_CH0_EVT = trig_q.ch0;
   assign O_CH1_EVT = trig_q.ch1;
   assign O_UPD_EVT = trig_q.upd;

   trig_selfclr_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch0 |=> !trig_q.ch0 || $past(wr_acc)) else $error("channel 0 trigger not self-cleared");
   upd_selfclr_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.upd |=> !trig_q.upd || $past(wr_acc)) else $error("update trigger not self-cleared");
   ch1_selfclr_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch1 |=> !trig_q.ch1)
      else $error("channel 1 trigger not self-cleared");
   flag_set_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch0 |=> flag0 && ist_q[tset_pkg::ST_F0]) else $error("channel 0 flag not set");
   ch1_flag_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch1 |=> flag1) else $error("channel 1 flag not set");
   zero_write_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_SWEVT && !req.writedata[tset_pkg::BIT_CH0] |=> !trig_q.ch0)
      else $error("zero write fired channel 0");
   zero_upd_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_SWEVT && !req.writedata[tset_pkg::BIT_UPD] |=> !trig_q.upd)
      else $error("zero write fired update");
   zero_ch1_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_SWEVT && !req.writedata[tset_pkg::BIT_CH1] |=> !trig_q.ch1)
      else $error("zero write fired channel 1");
   trig_map_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_SWEVT && req.writedata[tset_pkg::BIT_UPD]
      |=> trig_q.upd ##1 psc_cnt == 16'h0000)
      else $error("update trigger bit not mapped");
   ch0_map_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_SWEVT && req.writedata[tset_pkg::BIT_CH0] |=> trig_q.ch0)
      else $error("channel 0 trigger bit not mapped");
   ch1_map_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_SWEVT && req.writedata[tset_pkg::BIT_CH1] |=> trig_q.ch1)
      else $error("channel 1 trigger bit not mapped");
   dma0_pulse_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch0 && ctrl_q[tset_pkg::CTRL_DMA0] |=> O_DMA_REQ0)
      else $error("channel 0 dma request missing");
   dma1_pulse_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch1 && ctrl_q[tset_pkg::CTRL_DMA1] |=> O_DMA_REQ1)
      else $error("channel 1 dma request missing");
   irq_raise_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      ist_q[tset_pkg::ST_F0] && imask_q[tset_pkg::ST_F0] && ctrl_q[tset_pkg::CTRL_REQ0] |-> O_IRQ)
      else $error("enabled channel 0 interrupt not raised");
   irq_quiet_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      ist_q == '0 |-> !O_IRQ)
      else $error("interrupt raised without status");
   over_status_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch0 && chctl0_q[tset_pkg::CHC_IN0] && flag0 |=> over0 && ist_q[tset_pkg::ST_O0])
      else $error("overcapture status not set");
   ch1_capture_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      trig_q.ch1 && chctl0_q[tset_pkg::CHC_IN1] |=> cv1 == $past(cnt))
      else $error("channel 1 capture value wrong");
   part_refuse_a: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
      wr_acc && req.address == tset_pkg::OFS_CHCTL0 && !full_word |=> O_RESPONSE == 2'h2 && $stable(chctl0_q))
      else $error("partial channel control write not refused");
endmodule // tset_top

// ===== tb/timer_software_event_trigger_tb_top.sv
`timescale 1ns/10ps
module timer_software_event_trigger_tb_top;
   localparam int WD_NS = 40000;

   typedef struct packed {
      logic rd;
      logic [3:0] be;
      logic [7:0] addr;
      logic [31:0] wd;
      logic [31:0] exp_rd;
      logic [1:0] exp_rsp;
      logic [7:0] exp_obs;
   } tset_row_t;

   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] address = 8'h00;
   logic read = 1'b0;
   logic write = 1'b0;
   logic [3:0] byteenable = 4'h0;
   logic [31:0] writedata = 32'h0;
   logic [31:0] readdata;
   logic waitrequest;
   logic [1:0] response;
   logic irq;
   logic dma0;
   logic dma1;
   logic ch0_evt;
   logic ch1_evt;
   logic upd_evt;
   int errors = 0;
   int n_checks = 0;
   tset_row_t rows [13];

   tset_top uut (
      .I_CLK_SYS(clk),
      .I_RST(rst),
      .I_ADDRESS(address),
      .I_READ(read),
      .I_WRITE(write),
      .I_BYTEENABLE(byteenable),
      .I_WRITEDATA(writedata),
      .O_READDATA(readdata),
      .O_WAITREQUEST(waitrequest),
      .O_RESPONSE(response),
      .O_IRQ(irq),
      .O_DMA_REQ0(dma0),
      .O_DMA_REQ1(dma1),
      .O_CH0_EVT(ch0_evt),
      .O_CH1_EVT(ch1_evt),
      .O_UPD_EVT(upd_evt)
   );

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic close_out;
      $display("checks=%0d errors=%0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // obs: [2:0] events at the answer edge, [5:3] one edge later, [7:6] dma one edge later
   task automatic bus(input logic rd, input logic [3:0] be, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rdat, output logic [1:0] rsp, output logic [7:0] obs);
      int n;
      n = 0;
      read <= rd;
      write <= ~rd;
      byteenable <= be;
      address <= a;
      writedata <= wd;
      @(posedge clk);
      while (waitrequest !== 1'b0 && n < 20) begin
         @(posedge clk);
         n++;
      end
      if (n >= 20) begin
         errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, waitrequest, 1'b0);
      end
      rdat = readdata;
      rsp = response;
      obs[2:0] = {ch1_evt, ch0_evt, upd_evt};
      read <= 1'b0;
      write <= 1'b0;
      @(posedge clk);
      obs[7:3] = {dma1, dma0, ch1_evt, ch0_evt, upd_evt};
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic [1:0] s;
      logic [7:0] o;
      bus(1'b0, 4'hF, a, d, r, s, o);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      logic [1:0] s;
      logic [7:0] o;
      bus(1'b1, 4'hF, a, 32'h0, r, s, o);
      chk(r, e);
   endtask

   initial begin
      #(WD_NS);
      errors++;
      close_out();
   end

   initial begin
      logic [31:0] r;
      logic [1:0] s;
      logic [7:0] o;
      rows = '{
         '{1'b0, 4'hF, 8'h00, 32'h000F_0000, 32'h0, 2'h0, 8'h00},
         '{1'b0, 4'hF, 8'h44, 32'h0000_001F, 32'h0, 2'h0, 8'h00},
         '{1'b0, 4'hF, 8'h14, 32'h0000_0000, 32'h0, 2'h0, 8'h00},
         '{1'b0, 4'hF, 8'h14, 32'h0000_0001, 32'h0, 2'h0, 8'h01},
         '{1'b0, 4'hF, 8'h14, 32'h0000_0002, 32'h0, 2'h0, 8'h42},
         '{1'b0, 4'hF, 8'h14, 32'h0000_0004, 32'h0, 2'h0, 8'h84},
         '{1'b0, 4'hF, 8'h14, 32'h0000_0007, 32'h0, 2'h0, 8'hC7},
         '{1'b1, 4'hF, 8'h10, 32'h0000_0000, 32'h13, 2'h0, 8'h00},
         '{1'b1, 4'hF, 8'h10, 32'h0000_0000, 32'h10, 2'h0, 8'h00},
         '{1'b0, 4'h3, 8'h18, 32'h0000_0001, 32'h0, 2'h2, 8'h00},
         '{1'b1, 4'hF, 8'h18, 32'h0000_0000, 32'h0, 2'h0, 8'h00},
         '{1'b1, 4'hF, 8'hFC, 32'h0000_0000, 32'h0, 2'h2, 8'h00},
         '{1'b1, 4'hF, 8'h14, 32'h0000_0000, 32'h0, 2'h0, 8'h00}
      };
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(rows[i].rd, rows[i].be, rows[i].addr, rows[i].wd, r, s, o);
         if (rows[i].rd) chk(r, rows[i].exp_rd);
         chk({30'h0, s}, {30'h0, rows[i].exp_rsp});
         chk({24'h0, o}, {24'h0, rows[i].exp_obs});
      end
      // forced captures with a frozen counter
      wr(tset_pkg::OFS_ARLD, 32'h0000_1234);
      wr(tset_pkg::OFS_CHCTL0, 32'h0000_0101);
      rd_chk(tset_pkg::OFS_CHCTL0, 32'h0000_0101);
      wr(tset_pkg::OFS_CTRL, 32'h000F_0010);
      wr(tset_pkg::OFS_SWEVT, 32'h0000_0001);
      rd_chk(tset_pkg::OFS_CNT, 32'h0000_1234);
      wr(tset_pkg::OFS_SWEVT, 32'h0000_0002);
      rd_chk(tset_pkg::OFS_CV0, 32'h0000_1234);
      wr(tset_pkg::OFS_SWEVT, 32'h0000_0006);
      rd_chk(tset_pkg::OFS_CV1, 32'h0000_1234);
      rd_chk(tset_pkg::OFS_STAT, 32'h0000_0017);
      rd_chk(tset_pkg::OFS_STAT, 32'h0000_0010);
      for (int k = 0; k < 2; k++) begin
         wr(tset_pkg::OFS_CTRL, 32'h000F_0010);
         wr(tset_pkg::OFS_SWEVT, 32'h0000_0001);
         wr(tset_pkg::OFS_CTRL, (k == 1) ? 32'h000F_0020 : 32'h000F_0000);
         wr(tset_pkg::OFS_SWEVT, 32'h0000_0001);
         rd_chk(tset_pkg::OFS_CNT, 32'h0000_0000);
      end
      // update in mid-prescale must restart the prescaler
      wr(tset_pkg::OFS_CTRL, 32'h000F_FF01);
      repeat (150) @(posedge clk);
      wr(tset_pkg::OFS_SWEVT, 32'h0000_0001);
      repeat (180) @(posedge clk);
      rd_chk(tset_pkg::OFS_CNT, 32'h0000_0000);
      wr(tset_pkg::OFS_CTRL, 32'h000F_0000);
      // interrupt: clear, masked, unmasked, cleared by read
      bus(1'b1, 4'hF, tset_pkg::OFS_INTSTAT, 32'h0, r, s, o);
      chk({31'h0, irq}, 32'h0);
      wr(tset_pkg::OFS_INTMASK, 32'h0000_0000);
      wr(tset_pkg::OFS_SWEVT, 32'h0000_0002);
      chk({31'h0, irq}, 32'h0);
      wr(tset_pkg::OFS_INTMASK, 32'h0000_0001);
      chk({31'h0, irq}, 32'h1);
      rd_chk(tset_pkg::OFS_INTSTAT, 32'h0000_0001);
      chk({31'h0, irq}, 32'h0);
      // second reset in mid-run
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk({26'h0, irq, dma0, dma1, ch0_evt, ch1_evt, upd_evt}, 32'h0);
      rst <= 1'b0;
      @(posedge clk);
      rd_chk(tset_pkg::OFS_CHCTL0, 32'h0000_0000);
      rd_chk(tset_pkg::OFS_ARLD, 32'h0000_FFFF);
      rd_chk(tset_pkg::OFS_STAT, 32'h0000_0000);
      close_out();
   end
endmodule // timer_software_event_trigger_tb_top
